// File: design/brcpu_unit.sv
/*
 * bit rotate / colour pack datapath slice: one request per cycle, result and
 * flag write enables registered one cycle later.
 * assumes: the sequencer presents operands and old flags with req_valid, and
 * applies d, c and z only where the matching write enables are set.
 */
`timescale 1ns/100ps
`include "brcpu_defs.svh"

// Contract
// - flag pair rotate: {c, z, d[31:2]}, new c=d[1], new z=d[0]
// - bit order flip reverses all 32 bits of d
// - widen 5:6:5 in d[15:0] to 8:8:8 in d[31:8], low byte zero
// - narrow takes d[31:27], d[23:18], d[15:11] into 16 low bits
// - rotate left d by s[4:0], register or immediate source
// - rotate carry is last bit out, or d[31] when count zero
// - byte rotate-in: {d[23:0], byte n of s}
// - short byte rotate-in takes source and selector from preceding prefix
// - nibble rotate-in: {d[27:0], nibble n of s}
// - short nibble rotate-in takes source and selector from preceding prefix
// - short word rotate-in shifts in the word chosen by preceding prefix
module brcpu_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request from the sequencer
    input wire logic req_valid,
    input wire brcpu_pkg::brcpu_req_t req,
    // result to the register file and flags
    output logic res_valid,
    output brcpu_pkg::brcpu_res_t res
);
    // ============================================================
    // prefix setup
    // the setup lives for exactly the next accepted instruction; idle cycles
    // in between keep it, reset discards it; the prefix is only a one-shot modifier
    brcpu_pkg::brcpu_op_t setup_kind;
    logic setup_live;
    logic [`BRCPU_DATA_W-1:0] setup_src;
    logic [`BRCPU_SEL_W-1:0] setup_sel;
    logic is_prefix;

    assign is_prefix = (req.op == brcpu_pkg::byte_select_prefix)
        || (req.op == brcpu_pkg::nibble_select_prefix)
        || (req.op == brcpu_pkg::word_select_prefix);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            setup_live <= 1'b0;
            setup_kind <= brcpu_pkg::byte_select_prefix;
            setup_src <= `BRCPU_DATA_RST;
            setup_sel <= `BRCPU_SEL_RST;
        end else if (req_valid) begin
            setup_live <= is_prefix;
            if (is_prefix) begin
                setup_kind <= req.op;
                setup_src <= req.s;
                setup_sel <= req.sel;
            end
        end
    end

    // ============================================================
    // operand choice for the rotate-in forms
    // without a matching prefix the short forms fall back to field 0 of s
    logic use_byte_setup;
    logic use_nib_setup;
    logic use_word_setup;
    logic [`BRCPU_DATA_W-1:0] byte_src;
    logic [`BRCPU_DATA_W-1:0] nib_src;
    logic [`BRCPU_DATA_W-1:0] word_src;
    logic [`BRCPU_SEL_W-1:0] byte_sel;
    logic [`BRCPU_SEL_W-1:0] nib_sel;
    logic [`BRCPU_SEL_W-1:0] word_sel;

    assign use_byte_setup = (req.op == brcpu_pkg::byte_rotate_in_short) && setup_live
        && (setup_kind == brcpu_pkg::byte_select_prefix);
    assign use_nib_setup = (req.op == brcpu_pkg::nibble_rotate_in_short) && setup_live
        && (setup_kind == brcpu_pkg::nibble_select_prefix);
    assign use_word_setup = (req.op == brcpu_pkg::word_rotate_in_short) && setup_live
        && (setup_kind == brcpu_pkg::word_select_prefix);

    assign byte_src = use_byte_setup ? setup_src : req.s;
    assign byte_sel = use_byte_setup ? setup_sel
        : ((req.op == brcpu_pkg::byte_rotate_in) ? req.sel : `BRCPU_SEL_RST);
    assign nib_src = use_nib_setup ? setup_src : req.s;
    assign nib_sel = use_nib_setup ? setup_sel
        : ((req.op == brcpu_pkg::nibble_rotate_in) ? req.sel : `BRCPU_SEL_RST);
    assign word_src = use_word_setup ? setup_src : req.s;
    assign word_sel = use_word_setup ? setup_sel : `BRCPU_SEL_RST;

    // ============================================================
    // field selectors and rotator
    logic [`BRCPU_BYTE_W-1:0] byte_field;
    logic [`BRCPU_NIB_W-1:0] nib_field;
    logic [`BRCPU_WORD_W-1:0] word_field;
    logic [`BRCPU_DATA_W-1:0] rotl_res;
    logic rotl_carry;

    brcpu_field_sel #(.W(`BRCPU_BYTE_W), .SW(`BRCPU_BYTE_SEL_W)) u_byte_sel (
        .src(byte_src),
        .sel(byte_sel[`BRCPU_BYTE_SEL_W-1:0]),
        .field(byte_field)
    );

    brcpu_field_sel #(.W(`BRCPU_NIB_W), .SW(`BRCPU_NIB_SEL_W)) u_nib_sel (
        .src(nib_src),
        .sel(nib_sel[`BRCPU_NIB_SEL_W-1:0]),
        .field(nib_field)
    );

    brcpu_field_sel #(.W(`BRCPU_WORD_W), .SW(`BRCPU_WORD_SEL_W)) u_word_sel (
        .src(word_src),
        .sel(word_sel[`BRCPU_WORD_SEL_W-1:0]),
        .field(word_field)
    );

    brcpu_rotl u_rotl (
        .d(req.d),
        .cnt(req.s[`BRCPU_CNT_W-1:0]),
        .res(rotl_res),
        .carry(rotl_carry)
    );

    // ============================================================
    // result datapath
    logic [`BRCPU_DATA_W-1:0] next_d;
    logic next_d_we;
    logic next_c;
    logic next_z;
    logic [`BRCPU_DATA_W-1:0] flipped;

    always_comb begin
        for (int i = 0; i < `BRCPU_DATA_W; i++) begin
            flipped[i] = req.d[`BRCPU_DATA_W-1-i];
        end
    end

    always_comb begin
        next_d = req.d;
        next_d_we = 1'b1;
        next_c = req.c;
        next_z = 1'b0;
        case (req.op)
            brcpu_pkg::flag_pair_right_rotate: begin
                next_d = {req.c, req.z, req.d[`BRCPU_DATA_W-1:2]};
                next_c = req.d[1];
                next_z = req.d[0];
            end
            brcpu_pkg::bit_order_flip: begin
                next_d = flipped;
            end
            brcpu_pkg::color_565_widen: begin
                next_d = {req.d[`BRCPU_R5_HI:`BRCPU_R5_LO], req.d[15:13],
                    req.d[`BRCPU_G6_HI:`BRCPU_G6_LO], req.d[10:9],
                    req.d[`BRCPU_B5_HI:`BRCPU_B5_LO], req.d[4:2], 8'h00};
            end
            brcpu_pkg::color_888_narrow: begin
                next_d = {16'h0000, req.d[`BRCPU_R8_HI:`BRCPU_R8_LO],
                    req.d[`BRCPU_G8_HI:`BRCPU_G8_LO],
                    req.d[`BRCPU_B8_HI:`BRCPU_B8_LO]};
            end
            brcpu_pkg::rotate_left: begin
                next_d = rotl_res;
                next_c = rotl_carry;
            end
            brcpu_pkg::byte_rotate_in,
            brcpu_pkg::byte_rotate_in_short: begin
                next_d = {req.d[23:0], byte_field};
            end
            brcpu_pkg::nibble_rotate_in,
            brcpu_pkg::nibble_rotate_in_short: begin
                next_d = {req.d[27:0], nib_field};
            end
            brcpu_pkg::word_rotate_in_short: begin
                next_d = {req.d[15:0], word_field};
            end
            default: begin
                // prefixes only leave a setup, nothing is written back
                next_d_we = 1'b0;
            end
        endcase
        // zero flag follows the result except where the op defines its own
        if (req.op != brcpu_pkg::flag_pair_right_rotate) begin
            next_z = (next_d == `BRCPU_DATA_RST);
        end
    end

    // ============================================================
    // result register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= req_valid;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            res <= '0;
        end else if (req_valid) begin
            res.d <= next_d;
            res.d_we <= next_d_we;
            res.c <= next_c;
            res.z <= next_z;
            // flags held back unless the suffix asks; prefixes never write them
            res.c_we <= next_d_we && ((req.suffix == brcpu_pkg::carry_write_suffix)
                || (req.suffix == brcpu_pkg::both_flags_write_suffix));
            res.z_we <= next_d_we && ((req.suffix == brcpu_pkg::zero_flag_write_suffix)
                || (req.suffix == brcpu_pkg::both_flags_write_suffix));
        end else begin
            res.d_we <= 1'b0;
            res.c_we <= 1'b0;
            res.z_we <= 1'b0;
        end
    end

    // ============================================================
    // checks
    a_flag_pair_rot: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::flag_pair_right_rotate |=>
        res.d == {$past(req.c), $past(req.z), $past(req.d[31:2])}
        && res.c == $past(req.d[1]) && res.z == $past(req.d[0]))
        else $error("flag pair rotate result wrong");

    a_bit_flip: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::bit_order_flip |=>
        res.d[31] == $past(req.d[0]) && res.d[0] == $past(req.d[31])
        && res.d[16] == $past(req.d[15]))
        else $error("bit order flip wrong");

    a_color_widen: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::color_565_widen |=>
        res.d[7:0] == 8'h00 && res.d[31:27] == $past(req.d[15:11])
        && res.d[23:18] == $past(req.d[10:5]) && res.d[10:8] == $past(req.d[4:2]))
        else $error("colour widen wrong");

    a_color_narrow: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::color_888_narrow |=>
        res.d[31:16] == 16'h0000 && res.d[15:11] == $past(req.d[31:27])
        && res.d[10:5] == $past(req.d[23:18]) && res.d[4:0] == $past(req.d[15:11]))
        else $error("colour narrow wrong");

    a_rotl_data: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::rotate_left && req.s[4:0] == 5'h01 |=>
        res.d == {$past(req.d[30:0]), $past(req.d[31])})
        else $error("rotate left by one wrong");

    a_rotl_carry: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::rotate_left |=>
        res.c == (($past(req.s[4:0]) == 5'h00) ? $past(req.d[31])
        : ((($past(req.d) >> (6'd32 - {1'b0, $past(req.s[4:0])})) & 32'h1) != 32'h0)))
        else $error("rotate left carry wrong");

    a_byte_rot_in: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::byte_rotate_in && req.sel[1:0] == 2'h3 |=>
        res.d == {$past(req.d[23:0]), $past(req.s[31:24])})
        else $error("byte rotate-in wrong");

    a_byte_prefix: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::byte_select_prefix && req.sel[1:0] == 2'h1
        ##1 req_valid && req.op == brcpu_pkg::byte_rotate_in_short |=>
        res.d[7:0] == $past(req.s[15:8], 2))
        else $error("prefixed byte rotate-in wrong");

    a_nib_rot_in: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::nibble_rotate_in && req.sel == 3'h7 |=>
        res.d == {$past(req.d[27:0]), $past(req.s[31:28])})
        else $error("nibble rotate-in wrong");

    a_nib_prefix: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::nibble_select_prefix && req.sel == 3'h2
        ##1 req_valid && req.op == brcpu_pkg::nibble_rotate_in_short |=>
        res.d[3:0] == $past(req.s[11:8], 2))
        else $error("prefixed nibble rotate-in wrong");

    a_word_prefix: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.op == brcpu_pkg::word_select_prefix && req.sel[0]
        ##1 req_valid && req.op == brcpu_pkg::word_rotate_in_short |=>
        res.d == {$past(req.d[15:0]), $past(req.s[31:16], 2)})
        else $error("prefixed word rotate-in wrong");

    a_flag_write: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && req.suffix == brcpu_pkg::no_flag_write |=>
        !res.c_we && !res.z_we)
        else $error("flags written without suffix");
endmodule : brcpu_unit

// File: common/brcpu_defs.svh
/*
 * widths, field positions and reset values of the bit rotate / colour pack unit.
 * assumes: included by bare name from the package and the design files.
 */
`ifndef BRCPU_DEFS_SVH
`define BRCPU_DEFS_SVH

// ============================================================
// widths
`define BRCPU_DATA_W 32
`define BRCPU_BYTE_W 8
`define BRCPU_NIB_W 4
`define BRCPU_WORD_W 16
`define BRCPU_CNT_W 5

// ============================================================
// selector widths
`define BRCPU_SEL_W 3
`define BRCPU_BYTE_SEL_W 2
`define BRCPU_NIB_SEL_W 3
`define BRCPU_WORD_SEL_W 1

// ============================================================
// colour field positions, 5:6:5 source
`define BRCPU_R5_HI 15
`define BRCPU_R5_LO 11
`define BRCPU_G6_HI 10
`define BRCPU_G6_LO 5
`define BRCPU_B5_HI 4
`define BRCPU_B5_LO 0

// ============================================================
// colour field positions, 8:8:8 source (top bits kept when narrowing)
`define BRCPU_R8_HI 31
`define BRCPU_R8_LO 27
`define BRCPU_G8_HI 23
`define BRCPU_G8_LO 18
`define BRCPU_B8_HI 15
`define BRCPU_B8_LO 11

// ============================================================
// reset values
`define BRCPU_DATA_RST 32'h0000_0000
`define BRCPU_SEL_RST 3'h0

`endif

// File: common/brcpu_pkg.sv
/*
 * types of the bit rotate / colour pack unit: operation codes, flag write
 * suffix, request and result carriers.
 * assumes: brcpu_defs.svh is on the include path.
 */
`include "brcpu_defs.svh"

package brcpu_pkg;

    // ============================================================
    // operations
    typedef enum logic [3:0] {
        flag_pair_right_rotate,
        bit_order_flip,
        color_565_widen,
        color_888_narrow,
        rotate_left,
        byte_rotate_in,
        byte_rotate_in_short,
        nibble_rotate_in,
        nibble_rotate_in_short,
        word_rotate_in_short,
        byte_select_prefix,
        nibble_select_prefix,
        word_select_prefix
    } brcpu_op_t;

    // ============================================================
    // flag write suffix
    typedef enum logic [1:0] {
        no_flag_write,
        carry_write_suffix,
        zero_flag_write_suffix,
        both_flags_write_suffix
    } brcpu_suffix_t;

    // ============================================================
    // carriers
    typedef struct packed {
        brcpu_op_t op;
        logic [`BRCPU_DATA_W-1:0] d;
        logic [`BRCPU_DATA_W-1:0] s;
        logic [`BRCPU_SEL_W-1:0] sel;
        logic c;
        logic z;
        brcpu_suffix_t suffix;
    } brcpu_req_t;

    typedef struct packed {
        logic [`BRCPU_DATA_W-1:0] d;
        logic d_we;
        logic c;
        logic z;
        logic c_we;
        logic z_we;
    } brcpu_res_t;

endpackage : brcpu_pkg

// File: design/brcpu_field_sel.sv
/*
 * field selector: picks field number sel, of width w, out of a 32-bit word.
 * assumes: sel never names a field beyond the word.
 */
`timescale 1ns/100ps
`include "brcpu_defs.svh"

module brcpu_field_sel #(
    parameter int W = 8,
    parameter int SW = 2
) (
    // source
    input wire logic [`BRCPU_DATA_W-1:0] src,
    input wire logic [SW-1:0] sel,
    // field
    output logic [W-1:0] field
);
    logic [`BRCPU_DATA_W-1:0] shifted;

    assign shifted = src >> (sel * W);
    assign field = shifted[W-1:0];
endmodule : brcpu_field_sel

// File: design/brcpu_rotl.sv
/*
 * 32-bit left rotator with the carry result of the rotate instruction.
 * assumes: purely combinational, driven from the unit's request.
 */
`timescale 1ns/100ps
`include "brcpu_defs.svh"

module brcpu_rotl (
    // operand
    input wire logic [`BRCPU_DATA_W-1:0] d,
    input wire logic [`BRCPU_CNT_W-1:0] cnt,
    // result
    output logic [`BRCPU_DATA_W-1:0] res,
    output logic carry
);
    logic [2*`BRCPU_DATA_W-1:0] dbl;

    // doubled word shifted, upper half kept
    assign dbl = {d, d} << cnt;
    assign res = dbl[2*`BRCPU_DATA_W-1:`BRCPU_DATA_W];
    // the last bit out of bit 31 wraps into bit 0
    assign carry = (cnt != 5'h0) ? res[0] : d[`BRCPU_DATA_W-1];
endmodule : brcpu_rotl

// File: sim/brcpu_seq_model.sv
/*
 * sequencer / register file model: applies each result of the unit to a
 * destination register and to the carry and zero flags.
 * assumes: same clock and reset as the unit; one result per res_valid cycle.
 */
`timescale 1ns/100ps

module brcpu_seq_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // result from the unit
    input wire logic res_valid,
    input wire brcpu_pkg::brcpu_res_t res,
    // architectural state
    output logic [31:0] dest,
    output logic flag_c,
    output logic flag_z
);

    // ============================================================
    // write-back: a result lands only where its enable says so
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dest <= 32'h0;
            flag_c <= 1'h0;
            flag_z <= 1'h0;
        end else if (res_valid) begin
            if (res.d_we) dest <= res.d;
            if (res.c_we) flag_c <= res.c;
            if (res.z_we) flag_z <= res.z;
        end
    end

endmodule : brcpu_seq_model

// File: sim/test_bit_rotate_color_pack_unit.sv
/*
 * self-checking bench of the rotate / colour pack unit: corner cases, then
 * seeded random requests; a queue of expected results is checked per result.
 * assumes: brcpu_pkg compiled first; brcpu_seq_model applies the results.
 */
`timescale 1ns/100ps

module test_bit_rotate_color_pack_unit;

    // ============================================================
    // signals
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic req_valid = 1'h0;
    brcpu_pkg::brcpu_req_t req = '0;
    logic res_valid;
    brcpu_pkg::brcpu_res_t res;
    logic flag_c;
    logic flag_z;
    logic [31:0] dest;
    logic [31:0] exp_dest = 32'h0;
    int err_total = 0;
    int n_compared = 0;
    brcpu_pkg::brcpu_res_t exp_q[$];
    logic exp_c = 1'h0;
    logic exp_z = 1'h0;
    logic pf_on = 1'h0;
    brcpu_pkg::brcpu_op_t pf_op;
    logic [31:0] pf_s;
    logic [2:0] pf_sel;

    always #5 clk = ~clk;

    brcpu_unit u_brcpu_unit (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
        .res_valid(res_valid), .res(res));

    brcpu_seq_model u_brcpu_seq_model (.clk(clk), .rstn(rstn), .res_valid(res_valid),
        .res(res), .dest(dest), .flag_c(flag_c), .flag_z(flag_z));

    // ============================================================
    // expected values
    function automatic logic is_pf(input brcpu_pkg::brcpu_op_t op);
        return op inside {brcpu_pkg::byte_select_prefix, brcpu_pkg::nibble_select_prefix,
            brcpu_pkg::word_select_prefix};
    endfunction : is_pf

    function automatic brcpu_pkg::brcpu_res_t expect_of(input brcpu_pkg::brcpu_req_t q);
        brcpu_pkg::brcpu_res_t r;
        logic [31:0] s;
        logic [2:0] n;
        int k;
        r = '0;
        s = q.s;
        n = q.sel;
        k = int'(q.s[4:0]);
        // short forms: prefix setup only if it matches, else field 0 of own source
        if (q.op inside {brcpu_pkg::byte_rotate_in_short, brcpu_pkg::nibble_rotate_in_short,
                brcpu_pkg::word_rotate_in_short}) begin
            n = 3'h0;
            if (pf_on && (int'(pf_op) - int'(q.op) == ((q.op == brcpu_pkg::byte_rotate_in_short)
                    ? 4 : 3))) begin
                s = pf_s;
                n = pf_sel;
            end
        end
        case (q.op)
            brcpu_pkg::flag_pair_right_rotate: r.d = {q.c, q.z, q.d[31:2]};
            brcpu_pkg::bit_order_flip: for (int i = 0; i < 32; i++) r.d[i] = q.d[31 - i];
            brcpu_pkg::color_565_widen: r.d = {q.d[15:11], q.d[15:13], q.d[10:5], q.d[10:9],
                q.d[4:0], q.d[4:2], 8'h00};
            brcpu_pkg::color_888_narrow: r.d = {16'h0, q.d[31:27], q.d[23:18], q.d[15:11]};
            brcpu_pkg::rotate_left: r.d = (q.d << k) | (q.d >> (32 - k));
            brcpu_pkg::byte_rotate_in, brcpu_pkg::byte_rotate_in_short:
                r.d = {q.d[23:0], s[{n[1:0], 3'h0} +: 8]};
            brcpu_pkg::nibble_rotate_in, brcpu_pkg::nibble_rotate_in_short:
                r.d = {q.d[27:0], s[{n, 2'h0} +: 4]};
            brcpu_pkg::word_rotate_in_short: r.d = {q.d[15:0], s[{n[0], 4'h0} +: 16]};
            default: r.d = 32'h0;
        endcase
        r.c = q.c;
        r.z = (r.d == 32'h0);
        if (q.op == brcpu_pkg::flag_pair_right_rotate) {r.c, r.z} = q.d[1:0];
        if (q.op == brcpu_pkg::rotate_left) r.c = (k == 0) ? q.d[31] : r.d[0];
        // suffix encoding: bit 0 asks for carry, bit 1 for zero
        r.d_we = !is_pf(q.op);
        r.c_we = r.d_we && q.suffix[0];
        r.z_we = r.d_we && q.suffix[1];
        return r;
    endfunction : expect_of

    // ============================================================
    // compare and report
    task automatic cmp_d(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_d

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_d({31'h0, got}, {31'h0, exp});
    endtask : cmp_bit

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // ============================================================
    // drivers
    task automatic send(input brcpu_pkg::brcpu_op_t op, input logic [31:0] d,
        input logic [31:0] s, input logic [2:0] sel);
        brcpu_pkg::brcpu_req_t q;
        q = '{op, d, s, sel, 1'($urandom), 1'($urandom),
            brcpu_pkg::brcpu_suffix_t'($urandom_range(3, 0))};
        exp_q.push_back(expect_of(q));
        // any accepted request replaces or cancels the pending prefix
        pf_on = is_pf(op);
        pf_op = op;
        pf_s = s;
        pf_sel = sel;
        @(posedge clk);
        req <= q;
        req_valid <= 1'h1;
    endtask : send

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            req_valid <= 1'h0;
        end
    endtask : idle

    // ============================================================
    // result monitor, sampled mid-cycle where outputs are settled
    always @(negedge clk) begin : mon
        brcpu_pkg::brcpu_res_t e;
        if (!rstn) begin
            exp_q.delete();
            exp_c = 1'h0;
            exp_z = 1'h0;
            pf_on = 1'h0;
            exp_dest = 32'h0;
            cmp_bit(res_valid, 1'h0);
        end else begin
            cmp_bit(flag_c, exp_c);
            cmp_bit(flag_z, exp_z);
            cmp_d(dest, exp_dest);
            if (res_valid !== 1'h1) begin
                cmp_bit(res.d_we | res.c_we | res.z_we, 1'h0);
            end else if (exp_q.size() == 0) begin
                cmp_bit(res_valid, 1'h0);
            end else begin
                e = exp_q.pop_front();
                cmp_bit(res.d_we, e.d_we);
                cmp_bit(res.c_we, e.c_we);
                cmp_bit(res.z_we, e.z_we);
                if (e.d_we) begin
                    cmp_d(res.d, e.d);
                    cmp_bit(res.c, e.c);
                    cmp_bit(res.z, e.z);
                end
                if (e.c_we) exp_c = e.c;
                if (e.z_we) exp_z = e.z;
                if (e.d_we) exp_dest = e.d;
            end
        end
    end

    // ============================================================
    // main sequence
    initial begin
        void'($urandom(32'h56c4));
        repeat (16) @(posedge clk);
        rstn <= 1'h1;
        send(brcpu_pkg::rotate_left, 32'h8000_0001, 32'h1, 3'h0);
        send(brcpu_pkg::rotate_left, 32'h8000_0000, 32'hffff_ffe0, 3'h0);
        send(brcpu_pkg::rotate_left, 32'h0000_0003, 32'h1f, 3'h0);
        send(brcpu_pkg::flag_pair_right_rotate, 32'h0000_0002, 32'h0, 3'h0);
        send(brcpu_pkg::bit_order_flip, 32'h0000_0001, 32'h0, 3'h0);
        send(brcpu_pkg::color_565_widen, 32'hffff_ffff, 32'h0, 3'h0);
        send(brcpu_pkg::color_888_narrow, 32'hffff_ffff, 32'h0, 3'h0);
        send(brcpu_pkg::byte_rotate_in, 32'h1122_3344, 32'haabb_ccdd, 3'h3);
        send(brcpu_pkg::nibble_rotate_in, 32'h1122_3344, 32'h9abc_def0, 3'h7);
        // prefix survives idle cycles, then feeds the short form
        send(brcpu_pkg::byte_select_prefix, 32'h0, 32'h0123_4567, 3'h1);
        idle(3);
        send(brcpu_pkg::byte_rotate_in_short, 32'h00ff_00ff, 32'hffff_ffff, 3'h3);
        send(brcpu_pkg::byte_select_prefix, 32'h0, 32'h0123_4567, 3'h1);
        send(brcpu_pkg::byte_rotate_in_short, 32'h1, 32'h0, 3'h2);
        send(brcpu_pkg::nibble_select_prefix, 32'h0, 32'h8765_4321, 3'h2);
        send(brcpu_pkg::nibble_rotate_in_short, 32'h1, 32'h0, 3'h0);
        send(brcpu_pkg::word_select_prefix, 32'h0, 32'hbeef_0000, 3'h1);
        send(brcpu_pkg::word_rotate_in_short, 32'h0000_1234, 32'h0, 3'h0);
        // prefix cancelled by another request, and a prefix of the wrong kind
        send(brcpu_pkg::word_select_prefix, 32'h0, 32'hbeef_0000, 3'h1);
        send(brcpu_pkg::bit_order_flip, 32'h1, 32'h0, 3'h0);
        send(brcpu_pkg::word_rotate_in_short, 32'h5, 32'h0000_cafe, 3'h1);
        send(brcpu_pkg::byte_select_prefix, 32'h0, 32'hffff_ff00, 3'h3);
        send(brcpu_pkg::nibble_rotate_in_short, 32'h7, 32'h0000_000a, 3'h2);
        // prefix cleared by a reset in mid-run
        send(brcpu_pkg::nibble_select_prefix, 32'h0, 32'hffff_fff0, 3'h7);
        idle(2);
        rstn <= 1'h0;
        idle(2);
        rstn <= 1'h1;
        send(brcpu_pkg::nibble_rotate_in_short, 32'h3, 32'h0000_0009, 3'h0);
        for (int i = 0; i < 600; i++) begin
            send(brcpu_pkg::brcpu_op_t'($urandom_range(12, 0)), $urandom, $urandom,
                3'($urandom));
            if ($urandom_range(3, 0) == 0) idle(1);
        end
        idle(1);
        for (int i = 0; i < 8 && exp_q.size() != 0; i++) @(posedge clk);
        if (exp_q.size() != 0) err_total++;
        report_and_stop();
    end

endmodule : test_bit_rotate_color_pack_unit
